//--- ccl_pkg.sv
// Purpose: shared constants and carriers for the comparator control logic
// Assumes: 8-bit data space, byte addresses as printed
// Notes: no imports; users write ccl_pkg::name
package ccl_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h50;
    localparam logic [7:0] DIS_OFFSET = 8'h7F;
    // ==========================================================
    // control/status field positions
    localparam int POWER_OFF_BIT = 7;
    localparam int BANDGAP_BIT = 6;
    localparam int RESULT_BIT = 5;
    localparam int FLAG_BIT = 4;
    localparam int IRQ_ENABLE_BIT = 3;
    localparam int CAPTURE_BIT = 2;
    localparam int MODE_HI_BIT = 1;
    localparam int MODE_LO_BIT = 0;
    // input disable field positions
    localparam int POS_OFF_BIT = 0;
    localparam int NEG_OFF_BIT = 1;
    // ==========================================================
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] DIS_RESET = 2'h0;
    // interrupt mode codes
    localparam logic [1:0] MODE_TOGGLE = 2'h0;
    localparam logic [1:0] MODE_RESERVED = 2'h1;
    localparam logic [1:0] MODE_FALL = 2'h2;
    localparam logic [1:0] MODE_RISE = 2'h3;
    // synchroniser depth
    localparam int SYNC_STAGES = 2;
    // ==========================================================
    // register access from the processor data space
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } ccl_bus_req_t;
    // negative input source steering from the converter block
    typedef struct packed {
        logic mux_negative_enable;
        logic converter_enable;
        logic [2:0] channel_select_low;
    } ccl_mux_ctl_t;
endpackage : ccl_pkg

//--- ccl_sync2.sv
// Purpose: two-flop level synchroniser
// Assumes: asynchronous active-low reset to zero
// Notes: only the second stage leaves the module
`timescale 1ns/1ps
module ccl_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    // ==========================================================
    // metastability chain
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end
    assign q_o = sync_q;
endmodule : ccl_sync2

//--- ccl_comparator_ctrl.sv
// Purpose: digital control around an analog voltage comparator
// Assumes: register port in processor data space, all inputs synchronous except compare_raw_i and resetn_i
// Notes: outputs are registered; interrupt request lags the flag by one cycle
// Operation
// RL1: result is one when positive input voltage exceeds negative input voltage
// RL2: mux enabled and converter off: low channel bits pick channel pin 0..7
// RL3: mux disabled or converter on: dedicated negative pin feeds negative input
// RL4: writing one to bit 7 switches comparator power off, any time
// RL5: bit 6 one selects bandgap reference as positive input, else pin
// RL6: readable result is raw output through synchroniser, 1-2 cycles late
// RL7: flag bit 4 set when synchronised output shows selected event
// RL8: flag clears on interrupt vector execution or writing one to it
// RL9: request while flag, enable bit 3 and global enable all set
// RL10: mode 00 toggle, 10 falling, 11 rising, 01 reserved
// RL11: bit 2 one routes result to timer capture, else no connection
// RL12: software clears enable before changing power-off bit
// RL13: software clears enable before changing interrupt mode bits
// RL14: input disable bits 0/1 turn buffer off; port bit reads zero
// RL15: software keeps converter power reduction at zero when using the mux
// RL16: software sets timer capture interrupt enable for capture interrupts
// RL17: edge detection compares synchronised value against previous cycle
`timescale 1ns/1ps
module ccl_comparator_ctrl (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire ccl_pkg::ccl_bus_req_t bus_i,
    output logic [7:0] rdata_o,
    input wire ccl_pkg::ccl_mux_ctl_t mux_ctl_i,
    input wire logic compare_raw_i,
    input wire logic global_irq_enable_i,
    input wire logic irq_vector_ack_i,
    input wire logic positive_pin_digital_i,
    input wire logic negative_pin_digital_i,
    output logic compare_power_off_o,
    output logic bandgap_select_o,
    output logic negative_from_channel_o,
    output logic [2:0] negative_channel_o,
    output logic capture_signal_o,
    output logic irq_o,
    output logic positive_pin_input_off_o,
    output logic negative_pin_input_off_o,
    output logic positive_pin_read_o,
    output logic negative_pin_read_o
);
    logic rst_n;
    logic res_sync;
    logic prev_q, prev_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [1:0] dis_q, dis_d;
    logic [7:0] rdata_q, rdata_d;
    logic evt;
    logic ctrl_wr, dis_wr;
    logic irq_q, irq_d;
    logic cap_q, cap_d;
    logic nsel_q, nsel_d;
    logic [2:0] nch_q, nch_d;
    logic pos_rd_q, pos_rd_d;
    logic neg_rd_q, neg_rd_d;
    logic [1:0] mode;
    // ==========================================================
    // reset release
    ccl_sync2 #(.WIDTH(1)) u_rst_sync (
        .clk_i(mclk_i),
        .rst_n_i(resetn_i),
        .d_i(1'b1),
        .q_o(rst_n)
    );
    // comparator output into the clock domain
    ccl_sync2 #(.WIDTH(1)) u_res_sync (
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .d_i(compare_raw_i), // analog decision, high when positive side higher [RL1]
        .q_o(res_sync) // [RL6]
    );
    // ==========================================================
    // register writes, event detection, flag
    assign ctrl_wr = bus_i.we && (bus_i.addr == ccl_pkg::CTRL_OFFSET);
    assign dis_wr = bus_i.we && (bus_i.addr == ccl_pkg::DIS_OFFSET);
    assign mode = {ctrl_q[ccl_pkg::MODE_HI_BIT], ctrl_q[ccl_pkg::MODE_LO_BIT]};
    always_comb begin
        prev_d = res_sync; // previous-cycle copy [RL17]
        case (mode) // [RL10]
            ccl_pkg::MODE_TOGGLE: evt = res_sync ^ prev_q;
            ccl_pkg::MODE_FALL: evt = prev_q & ~res_sync;
            ccl_pkg::MODE_RISE: evt = res_sync & ~prev_q;
            default: evt = 1'b0;
        endcase
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = bus_i.wdata; // power off [RL4], bandgap [RL5]
            ctrl_d[ccl_pkg::RESULT_BIT] = 1'b0;
            ctrl_d[ccl_pkg::FLAG_BIT] = ctrl_q[ccl_pkg::FLAG_BIT]
                & ~bus_i.wdata[ccl_pkg::FLAG_BIT]; // write one clears [RL8]
        end
        if (irq_vector_ack_i) begin
            ctrl_d[ccl_pkg::FLAG_BIT] = 1'b0; // vector clears [RL8]
        end
        if (evt) begin
            ctrl_d[ccl_pkg::FLAG_BIT] = 1'b1; // set beats clear [RL7]
        end
        dis_d = dis_wr ? bus_i.wdata[1:0] : dis_q;
    end
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= ccl_pkg::CTRL_RESET;
            dis_q <= ccl_pkg::DIS_RESET;
            prev_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            dis_q <= dis_d;
            prev_q <= prev_d;
        end
    end
    // ==========================================================
    // registered outputs and read data
    always_comb begin
        irq_d = ctrl_q[ccl_pkg::FLAG_BIT] & ctrl_q[ccl_pkg::IRQ_ENABLE_BIT]
            & global_irq_enable_i; // [RL9]
        cap_d = ctrl_q[ccl_pkg::CAPTURE_BIT] & res_sync; // [RL11]
        nsel_d = mux_ctl_i.mux_negative_enable & ~mux_ctl_i.converter_enable; // [RL2] [RL3]
        nch_d = mux_ctl_i.channel_select_low; // [RL2]
        pos_rd_d = positive_pin_digital_i & ~dis_q[ccl_pkg::POS_OFF_BIT]; // [RL14]
        neg_rd_d = negative_pin_digital_i & ~dis_q[ccl_pkg::NEG_OFF_BIT]; // [RL14]
        rdata_d = 8'h00; // unmapped reads zero
        if (bus_i.re && bus_i.addr == ccl_pkg::CTRL_OFFSET) begin
            rdata_d = ctrl_q;
            rdata_d[ccl_pkg::RESULT_BIT] = res_sync; // [RL6]
        end else if (bus_i.re && bus_i.addr == ccl_pkg::DIS_OFFSET) begin
            rdata_d = {6'h00, dis_q};
        end
    end
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
            cap_q <= 1'b0;
            nsel_q <= 1'b0;
            nch_q <= 3'h0;
            pos_rd_q <= 1'b0;
            neg_rd_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            irq_q <= irq_d;
            cap_q <= cap_d;
            nsel_q <= nsel_d;
            nch_q <= nch_d;
            pos_rd_q <= pos_rd_d;
            neg_rd_q <= neg_rd_d;
            rdata_q <= rdata_d;
        end
    end
    assign rdata_o = rdata_q;
    assign compare_power_off_o = ctrl_q[ccl_pkg::POWER_OFF_BIT];
    assign bandgap_select_o = ctrl_q[ccl_pkg::BANDGAP_BIT];
    assign negative_from_channel_o = nsel_q;
    assign negative_channel_o = nch_q;
    assign capture_signal_o = cap_q;
    assign irq_o = irq_q;
    assign positive_pin_input_off_o = dis_q[ccl_pkg::POS_OFF_BIT];
    assign negative_pin_input_off_o = dis_q[ccl_pkg::NEG_OFF_BIT];
    assign positive_pin_read_o = pos_rd_q;
    assign negative_pin_read_o = neg_rd_q;
    // ==========================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);
    sequence raw_rise_s;
        !compare_raw_i ##1 compare_raw_i [*2];
    endsequence
    sequence rise_seen_s;
        mode == ccl_pkg::MODE_RISE && res_sync && !prev_q;
    endsequence
    sequence fall_seen_s;
        mode == ccl_pkg::MODE_FALL && !res_sync && prev_q;
    endsequence
    sequence toggle_seen_s;
        mode == ccl_pkg::MODE_TOGGLE && (res_sync != prev_q);
    endsequence
    neg_source_a: assert property (negative_from_channel_o == // [RL3]
        $past(mux_ctl_i.mux_negative_enable && !mux_ctl_i.converter_enable))
        else $error("negative source select wrong");
    chan_pick_a: assert property (##1 negative_from_channel_o |-> // [RL2]
        negative_channel_o == $past(mux_ctl_i.channel_select_low))
        else $error("channel select not followed");
    power_off_a: assert property (ctrl_wr && bus_i.wdata[7] |=> compare_power_off_o) // [RL4]
        else $error("power off write lost");
    bandgap_sel_a: assert property (ctrl_wr |=> bandgap_select_o == $past(bus_i.wdata[6])) // [RL5]
        else $error("bandgap select not stored");
    sync_delay_a: assert property (raw_rise_s |=> res_sync) // [RL6]
        else $error("result not seen within two cycles");
    rise_flag_a: assert property (rise_seen_s |=> ctrl_q[ccl_pkg::FLAG_BIT]) // [RL7]
        else $error("rising edge did not set flag");
    reserved_mode_a: assert property (mode == ccl_pkg::MODE_RESERVED && // [RL10]
        !ctrl_q[ccl_pkg::FLAG_BIT] |=> !ctrl_q[ccl_pkg::FLAG_BIT])
        else $error("reserved mode set flag");
    flag_clear_a: assert property ((irq_vector_ack_i || (ctrl_wr && bus_i.wdata[4])) // [RL8]
        && !evt |=> !ctrl_q[ccl_pkg::FLAG_BIT])
        else $error("flag not cleared");
    irq_req_a: assert property (##1 irq_o == $past(ctrl_q[4] && ctrl_q[3] && // [RL9]
        global_irq_enable_i))
        else $error("interrupt request mismatch");
    capture_route_a: assert property (##1 capture_signal_o == $past(ctrl_q[2] && res_sync)) // [RL11]
        else $error("capture route mismatch");
    pin_off_a: assert property (dis_q[0] |=> !positive_pin_read_o) // [RL14]
        else $error("disabled pin read nonzero");
    // edge events, previous copy, pin gating, read-back and request blocking
    fall_flag_a: assert property (fall_seen_s |=> ctrl_q[ccl_pkg::FLAG_BIT]) // [RL7]
        else $error("falling edge did not set flag");
    toggle_flag_a: assert property (toggle_seen_s |=> ctrl_q[ccl_pkg::FLAG_BIT]) // [RL10]
        else $error("toggle did not set flag");
    prev_track_a: assert property (prev_q == $past(res_sync)) // [RL17]
        else $error("previous result copy stale");
    neg_pin_off_a: assert property (dis_q[ccl_pkg::NEG_OFF_BIT] |=> !negative_pin_read_o) // [RL14]
        else $error("disabled negative pin read nonzero");
    pin_follow_a: assert property (!dis_q[ccl_pkg::POS_OFF_BIT] |=> // [RL14]
        positive_pin_read_o == $past(positive_pin_digital_i))
        else $error("enabled pin read not passed");
    result_read_a: assert property (bus_i.re && bus_i.addr == ccl_pkg::CTRL_OFFSET |=> // [RL6]
        rdata_o[ccl_pkg::RESULT_BIT] == $past(res_sync))
        else $error("result bit read wrong");
    dis_read_a: assert property (bus_i.re && bus_i.addr == ccl_pkg::DIS_OFFSET |=> // [RL14]
        rdata_o == {6'h00, $past(dis_q)})
        else $error("disable register read wrong");
    irq_block_a: assert property (!ctrl_q[ccl_pkg::IRQ_ENABLE_BIT] |=> !irq_o) // [RL9]
        else $error("request without enable");
endmodule : ccl_comparator_ctrl

//--- ccl_analog_model.sv
// Purpose: analog comparator model facing the control block
// Assumes: voltages in millivolts; bandgap level is a plain default
// Notes: output holds its last value while powered off
`timescale 1ns/1ps
module ccl_analog_model #(
    parameter int BANDGAP_MV = 1100
) (
    input wire logic power_off_i,
    input wire logic bandgap_i,
    input wire logic from_channel_i,
    input wire logic [2:0] channel_i,
    input int pos_mv_i,
    input int neg_mv_i,
    input int chan_mv_i [8],
    output logic raw_o
);
    int p;
    int n;
    // ==========================================================
    // input selection and compare
    always_comb begin
        p = bandgap_i ? BANDGAP_MV : pos_mv_i;
        n = from_channel_i ? chan_mv_i[channel_i] : neg_mv_i;
    end
    initial raw_o = 1'b0;
    always @* begin
        if (!power_off_i) raw_o = (p > n);
    end
endmodule : ccl_analog_model

//--- comparator_control_logic_bench.sv
// Purpose: self-checking bench for the comparator control block
// Assumes: inputs driven at falling edges
// Notes: analog side is a millivolt model
`timescale 1ns/1ps
module comparator_control_logic_bench;
    logic mclk = 0, resetn = 0, raw, gie = 0, ack = 0, pdig = 0, ndig = 0;
    ccl_pkg::ccl_bus_req_t bus = '0;
    ccl_pkg::ccl_mux_ctl_t mux = '0;
    logic [7:0] rdata;
    logic pwr, bg, nfc, cap, irq, poff, noff, prd, nrd;
    logic [2:0] nch;
    int pos = 500, neg = 900, chan [8];
    int fails = 0, n_tests = 0;
    // ==========================================================
    // clock, model and design
    initial forever #4 mclk = ~mclk;
    ccl_analog_model i_ccl_analog_model (.power_off_i(pwr), .bandgap_i(bg),
        .from_channel_i(nfc), .channel_i(nch), .pos_mv_i(pos), .neg_mv_i(neg),
        .chan_mv_i(chan), .raw_o(raw));
    ccl_comparator_ctrl i_ccl_comparator_ctrl (.mclk_i(mclk), .resetn_i(resetn),
        .bus_i(bus), .rdata_o(rdata), .mux_ctl_i(mux), .compare_raw_i(raw),
        .global_irq_enable_i(gie), .irq_vector_ack_i(ack),
        .positive_pin_digital_i(pdig), .negative_pin_digital_i(ndig),
        .compare_power_off_o(pwr), .bandgap_select_o(bg), .negative_from_channel_o(nfc),
        .negative_channel_o(nch), .capture_signal_o(cap), .irq_o(irq),
        .positive_pin_input_off_o(poff), .negative_pin_input_off_o(noff),
        .positive_pin_read_o(prd), .negative_pin_read_o(nrd));
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus = '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(negedge mclk) bus.we = 1'b0;
        @(negedge mclk); // idle edge between strobes
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        bus = '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(negedge mclk) bus.re = 1'b0;
        chk(rdata & m, e);
        @(negedge mclk); // idle edge between strobes
    endtask : rd
    task automatic wrap_up();
        $display("tests=%0d fails=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    // ==========================================================
    // scenarios
    task automatic t_regs();
        rd(8'h50, 8'hFF, 8'h00);
        rd(8'h51, 8'hFF, 8'h00);
        pdig = 1; ndig = 1;
        wr(8'h7F, 8'hFF); cyc(2);
        rd(8'h7F, 8'hFF, 8'h03);
        chk({6'h00, prd, nrd}, 8'h00);
        wr(8'h7F, 8'h01); cyc(2);
        chk({4'h0, prd, nrd, poff, noff}, 8'h06);
        wr(8'h50, 8'hC4); cyc(1); // enable clear while power changes
        rd(8'h50, 8'hDF, 8'hC4);
        chk({6'h00, pwr, bg}, 8'h03);
        wr(8'h50, 8'h40); cyc(3); // enable still clear
        rd(8'h50, 8'h20, 8'h20);
        wr(8'h50, 8'h00); cyc(3);
        wr(8'h50, 8'h10);
        $display("done regs");
    endtask : t_regs
    task automatic t_mux();
        mux = '{mux_negative_enable: 1'b1, converter_enable: 1'b0, channel_select_low: 3'h0};
        for (int c = 0; c < 8; c++) begin
            mux.channel_select_low = 3'(c); // power reduction held at zero
            chan[c] = 100; cyc(4);
            chk({4'h0, nfc, nch}, 8'(8 + c));
            rd(8'h50, 8'h20, 8'h20);
            chan[c] = 900;
        end
        mux.converter_enable = 1'b1; cyc(4);
        chk({7'h00, nfc}, 8'h00);
        rd(8'h50, 8'h20, 8'h00);
        mux = '0;
        $display("done mux");
    endtask : t_mux
    task automatic t_modes();
        logic [7:0] code [4] = '{8'h00, 8'h02, 8'h03, 8'h01};
        logic [7:0] up [4] = '{8'h10, 8'h00, 8'h10, 8'h00};
        logic [7:0] dn [4] = '{8'h10, 8'h10, 8'h00, 8'h00};
        for (int i = 0; i < 4; i++) begin
            wr(8'h50, 8'h10 | code[i]); // mode change with enable clear
            pos = 1000; cyc(5);
            rd(8'h50, 8'h10, up[i]);
            wr(8'h50, 8'h10 | code[i]);
            pos = 500; cyc(5);
            rd(8'h50, 8'h10, dn[i]);
            wr(8'h50, 8'h10 | code[i]);
        end
        $display("done modes");
    endtask : t_modes
    task automatic t_irq();
        wr(8'h50, 8'h03); // mode set before enable
        wr(8'h50, 8'h0B);
        pos = 1000; cyc(5);
        chk({7'h00, irq}, 8'h00);
        gie = 1; cyc(2);
        chk({7'h00, irq}, 8'h01);
        ack = 1; cyc(1);
        ack = 0; cyc(2);
        chk({7'h00, irq}, 8'h00);
        rd(8'h50, 8'h10, 8'h00);
        wr(8'h50, 8'h03);
        wr(8'h50, 8'h14); cyc(3); // timer capture enable set outside
        chk({7'h00, cap}, 8'h01);
        wr(8'h50, 8'h10); cyc(2);
        chk({7'h00, cap}, 8'h00);
        $display("done irq");
    endtask : t_irq
    // ==========================================================
    // main sequence and watchdog
    initial begin
        for (int c = 0; c < 8; c++) chan[c] = 900;
        cyc(4);
        resetn = 1; cyc(4);
        t_regs();
        t_mux();
        t_modes();
        t_irq();
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        wrap_up();
    end
endmodule : comparator_control_logic_bench
